// ---- dpram_host.sv ----
/*
 * Host-side controller for one port of an asynchronous dual-port RAM:
 * array reads and writes with byte selects, semaphore flag set and test.
 * Assumes pin inputs synchronous to MCLK and one request at a time.
 */
// Contract
// - the host holds its array or flag choice steady through each write.
// - address moves only with read/write, enable or both byte selects high.
// - the host drives write data only once device outputs are off.
// - with output enable low in a read/write timed write, widen the pulse.
`timescale 1ns/1ps
module dpram_host #(
   parameter int ADDR_W = 16,
   parameter int DATA_W = 16
) (
   input wire logic MCLK,
   input wire logic ARST_N,
   input wire logic REQ_VALID,
   output logic REQ_READY,
   input wire logic REQ_WRITE,
   input wire logic REQ_FLAG,
   input wire logic [ADDR_W-1:0] REQ_ADDR,
   input wire logic [DATA_W-1:0] REQ_WDATA,
   input wire logic [1:0] REQ_BYTE_N,
   output logic RSP_VALID,
   output logic [DATA_W-1:0] RSP_RDATA,
   output logic [ADDR_W-1:0] ADDR,
   output logic CHIP_EN_N,
   output logic FLAG_SELECT_N,
   output logic RW_N,
   output logic OUT_EN_N,
   output logic UPPER_BYTE_SEL_N,
   output logic LOWER_BYTE_SEL_N,
   input wire logic [DATA_W-1:0] DATA_I,
   output logic [DATA_W-1:0] DATA_O,
   output logic DATA_OE
);
   // refuse widths that the flag and byte lane logic cannot serve
   if (DATA_W != 16 || ADDR_W < dpram_pkg::FLAG_ADDR_BITS) begin : g_bad_w
      $error("dpram_host: unsupported width");
   end

   ////////////////////////////////////////////////////////////////////////
   dpram_pkg::state_t state_q;
   dpram_pkg::state_t state_d;
   logic write_q;
   logic flag_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DATA_W-1:0] wdata_q;
   logic [1:0] byte_n_q;
   logic ce_n_q;
   logic sem_n_q;
   logic rw_n_q;
   logic oe_n_q;
   logic ub_n_q;
   logic lb_n_q;
   logic data_oe_q;
   logic rsp_valid_q;
   logic [DATA_W-1:0] rdata_q;
   logic t_load;
   logic [3:0] t_value;
   logic t_done;

   function automatic logic [3:0] cyc(input int n);
      cyc = 4'(n);
   endfunction : cyc

   pulse_timer #(.WIDTH(4)) u_timer (
      .MCLK(MCLK),
      .ARST_N(ARST_N),
      .load(t_load),
      .value(t_value),
      .done(t_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // sequencing: every phase after setup has a minimum length from the timer
   wire take = (state_q == dpram_pkg::ST_IDLE) && REQ_VALID;
   assign REQ_READY = (state_q == dpram_pkg::ST_IDLE);
   // output enable stays high in writes, so the plain pulse suffices
   wire [3:0] wr_cycles = (dpram_pkg::PULSE_CYC > dpram_pkg::EOW_CYC) ?
      cyc(dpram_pkg::PULSE_CYC) : cyc(dpram_pkg::EOW_CYC);

   always_comb begin
      state_d = state_q;
      t_load = 1'b0;
      t_value = 4'h0;
      case (state_q)
         dpram_pkg::ST_IDLE: begin
            if (REQ_VALID) begin
               state_d = dpram_pkg::ST_SETUP;
            end
         end
         dpram_pkg::ST_SETUP: begin
            // address settles while all strobes are high
            state_d = write_q ? dpram_pkg::ST_TURNOFF : dpram_pkg::ST_READ;
            t_load = 1'b1;
            t_value = write_q ? cyc(dpram_pkg::HIZ_CYC)
               : cyc(dpram_pkg::ACCESS_CYC);
         end
         dpram_pkg::ST_READ: begin
            if (t_done) begin
               state_d = dpram_pkg::ST_RECOVER;
               t_load = 1'b1;
               t_value = cyc(1);
            end
         end
         dpram_pkg::ST_TURNOFF: begin
            // data bus stays released until device drivers are off
            if (t_done) begin
               state_d = dpram_pkg::ST_WRITE;
               t_load = 1'b1;
               t_value = wr_cycles;
            end
         end
         dpram_pkg::ST_WRITE: begin
            if (t_done) begin
               state_d = dpram_pkg::ST_RECOVER;
               t_load = 1'b1;
               t_value = cyc(1);
            end
         end
         dpram_pkg::ST_RECOVER: begin
            if (t_done) begin
               state_d = dpram_pkg::ST_IDLE;
            end
         end
         default: state_d = dpram_pkg::ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // pin levels decoded from the next state
   wire active_d = (state_d != dpram_pkg::ST_IDLE)
      && (state_d != dpram_pkg::ST_SETUP)
      && (state_d != dpram_pkg::ST_RECOVER);
   // enable falls together with read/write, so outputs stay off
   wire wr_d = (state_d == dpram_pkg::ST_TURNOFF)
      || (state_d == dpram_pkg::ST_WRITE);
   // the selection stays fixed for the whole active phase
   wire ce_n_d = !(active_d && !flag_q);
   wire sem_n_d = !(active_d && flag_q);
   // flag accesses keep both byte selects high; array uses request bytes
   wire ub_n_d = flag_q ? 1'b1 : (active_d ? byte_n_q[1] : 1'b1);
   wire lb_n_d = flag_q ? 1'b1 : (active_d ? byte_n_q[0] : 1'b1);
   // read/write rises on the same edge as every enable to end the write
   wire rw_n_d = !wr_d;
   wire oe_n_d = !(active_d && !write_q);
   wire data_oe_d = (state_d == dpram_pkg::ST_WRITE);
   wire done_read = (state_q == dpram_pkg::ST_READ) && t_done;

   // request capture; address only changes in idle, strobes all high
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         write_q <= 1'b0;
         flag_q <= 1'b0;
         addr_q <= '0;
         wdata_q <= dpram_pkg::DATA_RESET;
         byte_n_q <= 2'h3;
      end else if (take) begin
         write_q <= REQ_WRITE;
         flag_q <= REQ_FLAG;
         addr_q <= REQ_ADDR;
         // flag write carries its value on bit zero
         wdata_q <= REQ_FLAG ? {{(DATA_W-1){1'b0}}, REQ_WDATA[0]} : REQ_WDATA;
         byte_n_q <= REQ_BYTE_N;
      end
   end

   // pin registers
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_q <= dpram_pkg::ST_IDLE;
         ce_n_q <= 1'b1;
         sem_n_q <= 1'b1;
         rw_n_q <= 1'b1;
         oe_n_q <= 1'b1;
         ub_n_q <= 1'b1;
         lb_n_q <= 1'b1;
         data_oe_q <= 1'b0;
      end else begin
         state_q <= state_d;
         ce_n_q <= ce_n_d;
         sem_n_q <= sem_n_d;
         rw_n_q <= rw_n_d;
         oe_n_q <= oe_n_d;
         ub_n_q <= ub_n_d;
         lb_n_q <= lb_n_d;
         data_oe_q <= data_oe_d;
      end
   end

   // read capture; a flag read keeps only bit zero, all lines carry it
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         rdata_q <= dpram_pkg::DATA_RESET;
         rsp_valid_q <= 1'b0;
      end else begin
         rsp_valid_q <= done_read;
         if (done_read) begin
            rdata_q <= flag_q ? {{(DATA_W-1){1'b0}}, DATA_I[0]} : DATA_I;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // busy is not watched: reads of a word not being written elsewhere
   // are valid after access time alone
   assign ADDR = addr_q;
   assign CHIP_EN_N = ce_n_q;
   assign FLAG_SELECT_N = sem_n_q;
   assign RW_N = rw_n_q;
   assign OUT_EN_N = oe_n_q;
   assign UPPER_BYTE_SEL_N = ub_n_q;
   assign LOWER_BYTE_SEL_N = lb_n_q;
   assign DATA_O = wdata_q;
   assign DATA_OE = data_oe_q;
   assign RSP_VALID = rsp_valid_q;
   assign RSP_RDATA = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   AST_WRITE_DATA_LATE: assert property (@(posedge MCLK) disable iff (!ARST_N)
      $rose(DATA_OE) |-> !$past(RW_N, 1) && $past(OUT_EN_N, 1))
      else $error("write data driven before turn-off phase");
   AST_ADDR_STABLE: assert property (@(posedge MCLK) disable iff (!ARST_N)
      !$stable(ADDR) |-> (RW_N && CHIP_EN_N && FLAG_SELECT_N))
      else $error("address moved with strobes active");
   AST_SELECT_HELD: assert property (@(posedge MCLK) disable iff (!ARST_N)
      (!RW_N && !$past(RW_N, 1)) |-> $stable(CHIP_EN_N)
      && $stable(FLAG_SELECT_N))
      else $error("selection changed during write");
   AST_ONE_TARGET: assert property (@(posedge MCLK) disable iff (!ARST_N)
      !(!CHIP_EN_N && !FLAG_SELECT_N))
      else $error("array and flags selected together");
   AST_OE_OFF_IN_WRITE: assert property (@(posedge MCLK)
      disable iff (!ARST_N) !RW_N |-> OUT_EN_N)
      else $error("output enable low in write");
   AST_WRITE_PULSE: assert property (@(posedge MCLK) disable iff (!ARST_N)
      $fell(DATA_OE) |-> $past(DATA_OE, 2))
      else $error("write pulse too short");
   AST_FLAG_BYTES: assert property (@(posedge MCLK) disable iff (!ARST_N)
      !FLAG_SELECT_N |-> UPPER_BYTE_SEL_N && LOWER_BYTE_SEL_N)
      else $error("byte select low during flag access");
   AST_READ_ANSWER: assert property (@(posedge MCLK) disable iff (!ARST_N)
      ($fell(OUT_EN_N)) |-> ##3 RSP_VALID)
      else $error("read answer not on time");
   AST_STROBES_TOGETHER: assert property (@(posedge MCLK)
      disable iff (!ARST_N)
      $fell(RW_N) |-> (!CHIP_EN_N || !FLAG_SELECT_N)
      && $past(CHIP_EN_N, 1) && $past(FLAG_SELECT_N, 1))
      else $error("enable fell before read/write");
endmodule : dpram_host

// ---- dpram_host_bench.sv ----
/* Self-checking bench for the port controller against the RAM model.
   Assumes the controller walk: read answers 5 cycles, write 9 cycles. */
`timescale 1ns/1ps
module dpram_host_bench;
   logic mclk = 1'b0;
   logic arst_n = 1'b0;
   logic req_valid = 1'b0, req_write = 1'b0, req_flag = 1'b0;
   logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000, noise = 16'hA55A;
   logic [1:0] req_byte_n = 2'h3;
   logic req_ready, rsp_valid, ce_n, fs_n, rw_n, oe_n, ub_n, lb_n, data_oe;
   logic [15:0] rsp_rdata, addr, data_o, data_i, dev_q, rd;
   logic [1:0] dev_en;
   int mismatches = 0, checks = 0;
   always #5 mclk = ~mclk;
   always @(posedge mclk) noise <= ~noise; // floating lines never hold
   // wire level from both drivers, byte by byte
   assign data_i[15:8] = data_oe ? data_o[15:8] : dev_en[1] ? dev_q[15:8]
      : noise[15:8];
   assign data_i[7:0] = data_oe ? data_o[7:0] : dev_en[0] ? dev_q[7:0]
      : noise[7:0];
   dpram_host dpram_host_i (.MCLK(mclk), .ARST_N(arst_n),
      .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_WRITE(req_write),
      .REQ_FLAG(req_flag), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata),
      .REQ_BYTE_N(req_byte_n), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata),
      .ADDR(addr), .CHIP_EN_N(ce_n), .FLAG_SELECT_N(fs_n), .RW_N(rw_n),
      .OUT_EN_N(oe_n), .UPPER_BYTE_SEL_N(ub_n), .LOWER_BYTE_SEL_N(lb_n),
      .DATA_I(data_i), .DATA_O(data_o), .DATA_OE(data_oe));
   dpram_model dpram_model_i (.clk(mclk), .addr(addr), .chip_en_n(ce_n),
      .flag_select_n(fs_n), .rw_n(rw_n), .out_en_n(oe_n),
      .upper_byte_sel_n(ub_n), .lower_byte_sel_n(lb_n), .bus(data_i),
      .dq(dev_q), .dq_en(dev_en));
   ////////////////////////////////////////////////////////////////////////
   // both sides driving the data lines at once is a clash
   always @(negedge mclk) begin
      if (data_oe === 1'b1 && dev_en !== 2'b00) begin
         mismatches++;
         $display("wrong value bus owner expected 0 seen %b", dev_en);
      end
   end
   task automatic check(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   // one request, held until taken; latency checked against the walk
   task automatic access(input logic w, input logic f, input logic [15:0] a,
      input logic [15:0] d, input logic [1:0] bn);
      int n;
      @(negedge mclk);
      {req_valid, req_write, req_flag, req_addr, req_wdata} = {1'b1, w, f,
         a, d};
      req_byte_n = bn;
      n = 0;
      while (req_ready !== 1'b1 && n < 50) begin
         @(negedge mclk);
         n++;
      end
      @(negedge mclk);
      req_valid = 1'b0;
      n = 1;
      while (n < 20 && (w ? req_ready : rsp_valid) !== 1'b1) begin
         @(negedge mclk);
         n++;
      end
      check("latency", w ? 16'h0009 : 16'h0005, 16'(n));
      rd = rsp_rdata;
   endtask : access
   ////////////////////////////////////////////////////////////////////////
   // array words, byte lanes and the top address
   task automatic array_bytes;
      access(1, 0, 16'h00F0, 16'h1234, 2'h0);
      access(1, 0, 16'hFFFF, 16'hC3C3, 2'h0);
      access(0, 0, 16'h00F0, 16'h0000, 2'h0);
      check("word", 16'h1234, rd);
      access(1, 0, 16'h00F0, 16'hABCD, 2'h1);
      access(1, 0, 16'h00F0, 16'h5566, 2'h2);
      access(0, 0, 16'h00F0, 16'h0000, 2'h1);
      check("upper", 16'hAB00, rd & 16'hFF00);
      access(0, 0, 16'hFFFF, 16'h0000, 2'h0);
      check("top word", 16'hC3C3, rd);
   endtask : array_bytes
   // every flag set from bit zero through a high alias, read back clean
   task automatic flags;
      // upper data bits set, so only bit zero may reach the flag
      for (int i = 0; i < 8; i++) begin
         access(1, 1, 16'hFFF8 | 16'(i), {15'h7FFF, i[0]}, 2'h0);
      end
      for (int i = 0; i < 8; i++) begin
         access(0, 1, 16'(i), 16'h0000, 2'h3);
         check("flag", {15'h0000, i[0]}, rd);
      end
      access(0, 0, 16'h00F0, 16'h0000, 2'h0);
      check("word after flags", 16'hAB66, rd);
   endtask : flags
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : print_verdict
   ////////////////////////////////////////////////////////////////////////
   // main sequence and watchdog
   initial begin
      repeat (8) @(posedge mclk);
      check("idle pins", 16'h003F,
         {10'h000, ce_n, fs_n, rw_n, oe_n, ub_n, lb_n});
      @(negedge mclk);
      arst_n = 1'b1;
      array_bytes();
      flags();
      print_verdict();
   end
   initial begin
      #50000;
      mismatches++;
      print_verdict();
   end
endmodule : dpram_host_bench

// ---- dpram_model.sv ----
/* Behavioural model of one port of the dual-port RAM with eight flags.
   Assumes pins change just after clk rises and are stable at each rise. */
`timescale 1ns/1ps
module dpram_model #(
   parameter logic FLAG_INIT = 1'b1 // arbitrary start value of the flags
) (
   input wire logic clk,
   input wire logic [15:0] addr,
   input wire logic chip_en_n,
   input wire logic flag_select_n,
   input wire logic rw_n,
   input wire logic out_en_n,
   input wire logic upper_byte_sel_n,
   input wire logic lower_byte_sel_n,
   input wire logic [15:0] bus,
   output logic [15:0] dq,
   output logic [1:0] dq_en
);
   logic [15:0] mem [0:65535];
   logic [7:0] flag_q = {8{FLAG_INIT}};
   logic wr_q = 1'b0;
   logic fl_q;
   logic [15:0] d_q;
   logic [15:0] a_q;
   logic [1:0] be_n_q;
   ////////////////////////////////////////////////////////////////////////
   // routing and write window
   wire arr = !chip_en_n && flag_select_n;
   wire flg = chip_en_n && !flag_select_n;
   wire wr = (arr || flg) && !rw_n; // overlap of enable and rw
   wire rd = (arr || flg) && rw_n && !out_en_n;
   // no busy wait: read data is never held back
   assign dq_en[1] = rd && (flg || !upper_byte_sel_n);
   assign dq_en[0] = rd && (flg || !lower_byte_sel_n);
   assign dq = flg ? {16{flag_q[addr[2:0]]}} : mem[addr];
   ////////////////////////////////////////////////////////////////////////
   // data is taken at the last edge inside the window, so the late host
   // data turn-on is not missed; commit once the first strobe rises
   always @(posedge clk) begin
      wr_q <= wr;
      if (wr) begin
         d_q <= bus;
         a_q <= addr;
         fl_q <= flg;
         be_n_q <= {upper_byte_sel_n, lower_byte_sel_n};
      end
      if (wr_q && !wr) begin
         if (fl_q) flag_q[a_q[2:0]] <= d_q[0];
         if (!fl_q && !be_n_q[1]) mem[a_q][15:8] <= d_q[15:8];
         if (!fl_q && !be_n_q[0]) mem[a_q][7:0] <= d_q[7:0];
      end
   end
endmodule : dpram_model

// ---- dpram_pkg.sv ----
/*
 * Shared constants for the host-side port controller of an asynchronous
 * dual-port static RAM with semaphore flags.
 * Assumes a 100 MHz controller clock; all pin timing is counted in cycles.
 */
package dpram_pkg;
   localparam int CLK_PERIOD_NS = 10;
   // pin timing figures, nanoseconds, slower grade
   localparam int T_ENABLE_TO_EOW_NS = 15;
   localparam int T_WRITE_PULSE_NS = 15;
   localparam int T_WRITE_HIZ_NS = 10;
   localparam int T_DATA_SETUP_NS = 15;
   localparam int T_ACCESS_NS = 20;
   localparam int T_CYCLE_NS = 20;
   // least times round up
   localparam int ACCESS_CYC = (T_ACCESS_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int HIZ_CYC = (T_WRITE_HIZ_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int SETUP_CYC = (T_DATA_SETUP_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int EOW_CYC = (T_ENABLE_TO_EOW_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int PULSE_CYC = (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   localparam int RECOVER_CYC = (T_CYCLE_NS + CLK_PERIOD_NS - 1)
      / CLK_PERIOD_NS;
   // wide pulse when output enable stays low during the write
   localparam int WIDE_CYC = HIZ_CYC + SETUP_CYC;
   localparam int FLAG_ADDR_BITS = 3;
   localparam logic [15:0] DATA_RESET = 16'h0000;
   typedef enum logic [2:0] {
      ST_IDLE, ST_SETUP, ST_READ, ST_TURNOFF, ST_WRITE, ST_RECOVER
   } state_t;
endpackage : dpram_pkg

// ---- pulse_timer.sv ----
/*
 * Down counter that times each phase of a pin cycle after setup.
 * Assumes load and value are held low by the caller outside a phase.
 */
`timescale 1ns/1ps
module pulse_timer #(
   parameter int WIDTH = 4
) (
   input wire logic MCLK,
   input wire logic ARST_N,
   input wire logic load,
   input wire logic [WIDTH-1:0] value,
   output logic done
);
   logic [WIDTH-1:0] cnt_q;
   logic [WIDTH-1:0] cnt_d;

   // a one-bit counter cannot hold the longest phase load, 2 for read and write
   if (WIDTH < 2) begin : g_bad_width
      $error("pulse_timer: width too small");
   end

   // reload wins over counting so back-to-back phases never miss a count
   assign cnt_d = load ? value :
      (cnt_q != '0) ? cnt_q - WIDTH'(1) : cnt_q;
   // done is a pure count test: the caller's load depends on it, and a
   // term in load here would close a combinational loop
   assign done = (cnt_q == '0);

   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule : pulse_timer
